// *** rtl/pca_top.sv ***
// programmable counter array: time base, register slave and five modules
`timescale 1ns/1ps
`default_nettype none
module pca_top
    import pca_pkg::*;
(
    // clock and reset
    input  wire logic        clk_i,
    input  wire logic        rst_i,
    // wishbone classic slave
    input  wire logic        cyc_i,
    input  wire logic        stb_i,
    input  wire logic        we_i,
    input  wire logic [7:0]  adr_i,
    input  wire logic [3:0]  sel_i,
    input  wire logic [31:0] dat_i,
    output logic [31:0]      dat_o,
    output logic             ack_o,
    // processor state and timer 0
    input  wire logic        cpu_idle_i,
    input  wire logic        timer0_overflow_i,
    // port 1 pins
    input  wire logic [7:0]  port1_in_i,
    output logic [7:0]       port1_out_o,
    output logic [7:0]       port1_oe_n_o,
    // system
    output logic             irq_o,
    output logic             wdt_reset_o
);

    pca_state_type q;
    pca_state_type d;

    logic             req;
    logic             wr;
    logic [7:0]       wb;
    logic [3:0]       div_top;
    logic             div_hit;
    logic             src;
    logic             run;
    logic             tick;
    logic             ovf;
    logic             wrap;
    logic             eci_rise;
    logic [7:0]       rmux;

    logic [NUM_MODULES-1:0] wr_mode;
    logic [NUM_MODULES-1:0] wr_lo;
    logic [NUM_MODULES-1:0] wr_hi;
    logic [NUM_MODULES-1:0] ev;
    logic [NUM_MODULES-1:0] match;
    logic [NUM_MODULES-1:0] outs;
    logic [NUM_MODULES-1:0] drive;
    logic [NUM_MODULES-1:0] module_irq_enable;
    logic [6:0]             mode  [NUM_MODULES];
    logic [15:0]            cmp   [NUM_MODULES];

    genvar g;
    generate
        for (g = 0; g < NUM_MODULES; g++)
        begin : gen_mod
            pca_module u_mod (
                .clk_i     (clk_i),
                .rst_i     (rst_i),
                .wr_mode_i (wr_mode[g]),
                .wr_lo_i   (wr_lo[g]),
                .wr_hi_i   (wr_hi[g]),
                .wdata_i   (wb),
                .cnt_i     (q.cnt),
                .moved_i   (q.moved),
                .wrap_i    (wrap),
                .pin_i     (q.sync2[PIN_BASE-SYNC_LO+g]),
                .mode_o    (mode[g]),
                .cmp_o     (cmp[g]),
                .out_o     (outs[g]),
                .event_o   (ev[g]),
                .match_o   (match[g])
            );
            assign module_irq_enable[g]  = mode[g][MODE_MODULE_IRQ_ENABLE];
            // the pin is driven only when the module produces a level on it
            assign drive[g] = mode[g][MODE_TOG] | mode[g][MODE_PWM];
        end
    endgenerate

    // register decode and read mux
    always_comb
    begin
        req  = cyc_i & stb_i;
        // the write lands on the edge where the master samples ack
        wr   = req & q.ack & we_i & sel_i[0];
        wb   = dat_i[7:0];
        rmux = RST_BYTE;
        case (adr_i)
            OFS_COUNTER_CONTROL: rmux = {q.cf, q.cr, 1'b0, q.ccf};
            OFS_COUNTER_MODE_REGISTER: rmux = {q.idle_stop_bit, q.watchdog_enable_bit, 3'h0, q.cps, q.ecf};
            OFS_CL:   rmux = q.cnt[7:0];
            OFS_CH:   rmux = q.cnt[15:8];
            OFS_AUX:  rmux = {7'h00, q.six};
            default:  rmux = RST_BYTE;
        endcase
        for (int i = 0; i < NUM_MODULES; i++)
        begin
            wr_mode[i] = wr & (adr_i == 8'(OFS_MODE_BASE + OFS_STRIDE * i));
            wr_lo[i]   = wr & (adr_i == 8'(OFS_LO_BASE + OFS_STRIDE * i));
            wr_hi[i]   = wr & (adr_i == 8'(OFS_HI_BASE + OFS_STRIDE * i));
            if (adr_i == 8'(OFS_MODE_BASE + OFS_STRIDE * i))
            begin
                rmux = {1'b0, mode[i]};
            end
            if (adr_i == 8'(OFS_LO_BASE + OFS_STRIDE * i))
            begin
                rmux = cmp[i][7:0];
            end
            if (adr_i == 8'(OFS_HI_BASE + OFS_STRIDE * i))
            begin
                rmux = cmp[i][15:8];
            end
        end
    end

    // time base and control state
    always_comb
    begin
        d       = q;
        d.ack   = req & ~q.ack;
        if (req & ~q.ack)
        begin
            d.rdata = rmux;
        end
        // two stages on every pin of port 1 above bit 1
        d.sync1    = port1_in_i[7:SYNC_LO];
        d.sync2    = q.sync1;
        d.eci_prev = q.sync2[ECI_BIT-SYNC_LO];
        eci_rise   = q.sync2[ECI_BIT-SYNC_LO] & ~q.eci_prev;

        // oscillator prescaler free-runs; the count source picks one tap
        case (q.cps)
            SRC_OSC_SLOW: div_top = q.six ? DIV_SLOW_X6 : DIV_SLOW_X12;
            default:      div_top = q.six ? DIV_FAST_X6 : DIV_FAST_X12;
        endcase
        div_hit = (q.div >= 4'(div_top - 4'h1));
        d.div   = div_hit ? 4'h0 : 4'(q.div + 4'h1);
        case (q.cps)
            SRC_OSC_SLOW: src = div_hit;
            SRC_OSC_FAST: src = div_hit;
            SRC_TIMER0:   src = timer0_overflow_i;
            SRC_ECI:      src = eci_rise;
            default:      src = 1'b0;
        endcase
        run  = q.cr & ~(q.idle_stop_bit & cpu_idle_i);
        tick = run & src;
        wrap = tick & (&q.cnt[7:0]);
        ovf  = 1'b0;

        d.moved = 1'b0;
        if (wr && adr_i == OFS_CL)
        begin
            d.cnt[7:0] = wb;
            d.moved    = 1'b1;
        end
        else if (wr && adr_i == OFS_CH)
        begin
            d.cnt[15:8] = wb;
            d.moved     = 1'b1;
        end
        else if (tick)
        begin
            d.cnt   = 16'(q.cnt + 16'h0001);
            d.moved = 1'b1;
            ovf     = &q.cnt;
        end

        if (wr && adr_i == OFS_COUNTER_CONTROL)
        begin
            d.cf  = wb[COUNTER_CONTROL_CF];
            d.cr  = wb[COUNTER_CONTROL_CR];
            d.ccf = wb[NUM_MODULES-1:0];
        end
        if (wr && adr_i == OFS_COUNTER_MODE_REGISTER)
        begin
            d.idle_stop_bit = wb[COUNTER_MODE_REGISTER_IDLE_STOP_BIT];
            d.watchdog_enable_bit = wb[COUNTER_MODE_REGISTER_WATCHDOG_ENABLE_BIT];
            d.cps  = {wb[COUNTER_MODE_REGISTER_COUNT_SOURCE_SELECT_HI], wb[COUNTER_MODE_REGISTER_COUNT_SOURCE_SELECT_LO]};
            d.ecf  = wb[COUNTER_MODE_REGISTER_ECF];
        end
        if (wr && adr_i == OFS_AUX)
        begin
            d.six = wb[AUX_SIX];
        end
        // hardware set wins over a software clear in the same cycle
        d.cf  = d.cf | ovf;
        d.ccf = d.ccf | ev;

        d.wdt = q.watchdog_enable_bit & match[NUM_MODULES-1];
        d.irq = (d.cf & q.ecf) | (|(d.ccf & module_irq_enable));
    end

    always_ff @(posedge clk_i)
    begin
        if (rst_i)
        begin
            q.cf       <= 1'b0;
            q.cr       <= 1'b0;
            q.ccf      <= '0;
            q.idle_stop_bit     <= 1'b0;
            q.watchdog_enable_bit     <= 1'b0;
            q.cps      <= SRC_OSC_SLOW;
            q.ecf      <= 1'b0;
            q.six      <= 1'b0;
            q.cnt      <= RST_WORD;
            q.div      <= 4'h0;
            q.moved    <= 1'b0;
            q.ack      <= 1'b0;
            q.rdata    <= RST_BYTE;
            // start at the pulled-up idle level so release gives no false edge
            q.sync1    <= '1;
            q.sync2    <= '1;
            q.eci_prev <= 1'b1;
            q.wdt      <= 1'b0;
            q.irq      <= 1'b0;
        end
        else
        begin
            q <= d;
        end
    end

    assign ack_o        = q.ack;
    assign dat_o        = {24'h000000, q.rdata};
    assign irq_o        = q.irq;
    assign wdt_reset_o  = q.wdt;
    assign port1_out_o  = {outs, 3'h0};
    assign port1_oe_n_o = {~drive, 3'h7};

endmodule : pca_top
`default_nettype wire

// *** include/pca_pkg.sv ***
// constants, register map and state types of the counter array
//
// Summary of operation
// - one shared 16-bit counter, five modules
// - module n owns port 1 bit n+3
// - two-bit select picks counter increment source
// - idle-stop bit halts counter during idle
// - watchdog enable applies to module 4 only
// - overflow sets flag; irq when enabled
// - overflow flag cleared by software only
// - run-control bit starts and stops counter
// - event flags per module, software clears
// - mode bit 0 enables module interrupt
// - mode bit 1 selects pulse width modulation
// - mode bit 2 toggles pin on match
// - mode bit 3 sets flag on match
// - bits 4/5 enable falling/rising capture
// - mode bit 6 enables the comparator
// - byte pair holds capture or compare value
// - in modulation mode high byte sets duty
// - valid edge copies counter into pair
// - output low below duty, else high
// - duty reloads from high byte on wrap
// - module 4 match gives internal reset
package pca_pkg;

    localparam int NUM_MODULES = 5;
    localparam int PIN_BASE    = 3;
    localparam int ECI_BIT     = 2;
    localparam int SYNC_LO     = 2;

    // byte addresses, one aligned word each
    localparam logic [7:0] OFS_COUNTER_CONTROL      = 8'h00;
    localparam logic [7:0] OFS_COUNTER_MODE_REGISTER      = 8'h04;
    localparam logic [7:0] OFS_CL        = 8'h08;
    localparam logic [7:0] OFS_CH        = 8'h0C;
    localparam logic [7:0] OFS_AUX       = 8'h10;
    localparam logic [7:0] OFS_MODE_BASE = 8'h14;
    localparam logic [7:0] OFS_LO_BASE   = 8'h28;
    localparam logic [7:0] OFS_HI_BASE   = 8'h3C;
    localparam logic [7:0] OFS_STRIDE    = 8'h04;

    // counter_control_register fields
    localparam int COUNTER_CONTROL_CF = 7;
    localparam int COUNTER_CONTROL_CR = 6;
    // counter_mode_register fields
    localparam int COUNTER_MODE_REGISTER_IDLE_STOP_BIT = 7;
    localparam int COUNTER_MODE_REGISTER_WATCHDOG_ENABLE_BIT = 6;
    localparam int COUNTER_MODE_REGISTER_COUNT_SOURCE_SELECT_HI = 2;
    localparam int COUNTER_MODE_REGISTER_COUNT_SOURCE_SELECT_LO = 1;
    localparam int COUNTER_MODE_REGISTER_ECF  = 0;
    // auxiliary register: six-clock mode select
    localparam int AUX_SIX = 0;
    // module_mode_register fields
    localparam int MODE_MODULE_IRQ_ENABLE = 0;
    localparam int MODE_PWM  = 1;
    localparam int MODE_TOG  = 2;
    localparam int MODE_MAT  = 3;
    localparam int MODE_FALLING_EDGE_CAPTURE = 4;
    localparam int MODE_RISING_EDGE_CAPTURE = 5;
    localparam int MODE_COMPARATOR_ENABLE = 6;

    // count source encodings
    localparam logic [1:0] SRC_OSC_SLOW = 2'h0;
    localparam logic [1:0] SRC_OSC_FAST = 2'h1;
    localparam logic [1:0] SRC_TIMER0   = 2'h2;
    localparam logic [1:0] SRC_ECI      = 2'h3;

    // oscillator divide ratios (clk_i stands for the oscillator)
    localparam logic [3:0] DIV_SLOW_X6  = 4'h6;
    localparam logic [3:0] DIV_SLOW_X12 = 4'hC;
    localparam logic [3:0] DIV_FAST_X6  = 4'h2;
    localparam logic [3:0] DIV_FAST_X12 = 4'h4;

    // reset values
    localparam logic [7:0]  RST_BYTE = 8'h00;
    localparam logic [15:0] RST_WORD = 16'h0000;

    typedef struct packed {
        logic [6:0]  mode;
        logic [15:0] cmp;
        logic [7:0]  duty;
        logic        out;
        logic        pin_prev;
    } cm_state_type;

    typedef struct packed {
        logic                   cf;
        logic                   cr;
        logic [NUM_MODULES-1:0] ccf;
        logic                   idle_stop_bit;
        logic                   watchdog_enable_bit;
        logic [1:0]             cps;
        logic                   ecf;
        logic                   six;
        logic [15:0]            cnt;
        logic [3:0]             div;
        logic                   moved;
        logic                   ack;
        logic [7:0]             rdata;
        logic [5:0]             sync1;
        logic [5:0]             sync2;
        logic                   eci_prev;
        logic                   wdt;
        logic                   irq;
    } pca_state_type;

endpackage : pca_pkg

// *** rtl/pca_module.sv ***
// one capture/compare module: mode, compare pair, toggle and modulation output
`timescale 1ns/1ps
`default_nettype none
module pca_module
    import pca_pkg::*;
(
    // clock and reset
    input  wire logic        clk_i,
    input  wire logic        rst_i,
    // register writes
    input  wire logic        wr_mode_i,
    input  wire logic        wr_lo_i,
    input  wire logic        wr_hi_i,
    input  wire logic [7:0]  wdata_i,
    // time base
    input  wire logic [15:0] cnt_i,
    input  wire logic        moved_i,
    input  wire logic        wrap_i,
    // synchronized pin level
    input  wire logic        pin_i,
    // results
    output logic [6:0]       mode_o,
    output logic [15:0]      cmp_o,
    output logic             out_o,
    output logic             event_o,
    output logic             match_o
);

    cm_state_type q;
    cm_state_type d;
    logic         match;
    logic         cap;
    logic         pwm_on;

    always_comb
    begin
        d      = q;
        // only on a fresh counter value, so a stalled counter flags once
        match  = q.mode[MODE_COMPARATOR_ENABLE] & moved_i & (cnt_i == q.cmp);
        cap    = (pin_i & ~q.pin_prev & q.mode[MODE_RISING_EDGE_CAPTURE])
               | (~pin_i & q.pin_prev & q.mode[MODE_FALLING_EDGE_CAPTURE]);
        pwm_on = q.mode[MODE_PWM] & q.mode[MODE_COMPARATOR_ENABLE];
        d.pin_prev = pin_i;
        if (wr_mode_i)
        begin
            d.mode = wdata_i[6:0];
        end
        if (wr_lo_i)
        begin
            d.cmp[7:0] = wdata_i;
        end
        if (wr_hi_i)
        begin
            d.cmp[15:8] = wdata_i;
        end
        // a capture beats a software write landing in the same cycle
        if (cap)
        begin
            d.cmp = cnt_i;
        end
        if (pwm_on)
        begin
            if (wrap_i)
            begin
                d.duty = q.cmp[15:8];
            end
            d.out = (cnt_i[7:0] >= q.duty);
        end
        else if (match & q.mode[MODE_TOG])
        begin
            d.out = ~q.out;
        end
        event_o = (match & q.mode[MODE_MAT]) | cap;
        match_o = match;
    end

    always_ff @(posedge clk_i)
    begin
        if (rst_i)
        begin
            q.mode     <= 7'h00;
            q.cmp      <= RST_WORD;
            q.duty     <= RST_BYTE;
            q.out      <= 1'b0;
            q.pin_prev <= 1'b1;
        end
        else
        begin
            q <= d;
        end
    end

    assign mode_o = q.mode;
    assign cmp_o  = q.cmp;
    assign out_o  = q.out;

endmodule : pca_module
`default_nettype wire

// *** tb/pin_agent.sv ***
// far-side model: module capture pins and external count input
`timescale 1ns/1ps
`default_nettype none
module pin_agent
(
    // clock and pins
    input  wire logic       clk_i,
    output var logic [7:0]  pins_o
);
    // idle pins sit high, as a pulled-up port pin would
    initial pins_o = 8'hFF;
    // each level is held long enough to pass the sync stages
    task automatic set_pin(input int n, input logic v);
        @(posedge clk_i);
        pins_o[n] <= v;
        repeat (8) @(posedge clk_i);
    endtask : set_pin
    task automatic eci_pulse(input int k);
        repeat (k)
        begin
            set_pin(2, 1'b0);
            set_pin(2, 1'b1);
        end
    endtask : eci_pulse
endmodule : pin_agent
`default_nettype wire

// *** tb/pca_checker.sv ***
// assertions on the counter array ports
`timescale 1ns/1ps
`default_nettype none
module pca_checker
(
    // clock, reset and bus
    input wire logic        clk_i,
    input wire logic        rst_i,
    input wire logic        cyc_i,
    input wire logic        stb_i,
    input wire logic        we_i,
    input wire logic [31:0] dat_o,
    input wire logic        ack_o,
    // pins and system
    input wire logic [7:0]  port1_out_o,
    input wire logic [7:0]  port1_oe_n_o,
    input wire logic        irq_o,
    input wire logic        wdt_reset_o
);
    logic wr_q;
    logic wr2_q;
    default clocking cb @(posedge clk_i);
    endclocking
    default disable iff (rst_i);
    // a write may need one or two edges to reach a registered output
    always_ff @(posedge clk_i)
    begin
        wr_q  <= cyc_i && stb_i && we_i && ack_o;
        wr2_q <= wr_q;
    end
    sequence req_s;
        cyc_i && stb_i && !ack_o;
    endsequence
    sequence ack_s;
        ack_o ##1 !ack_o;
    endsequence
    ack_time_a: assert property (req_s |=> ack_s)
        else $error("bus answer late or long");
    ack_cause_a: assert property (ack_o |-> $past(cyc_i && stb_i))
        else $error("ack without request");
    ack_idle_a: assert property (!(cyc_i && stb_i) |=> !ack_o)
        else $error("ack while idle");
    rd_width_a: assert property (ack_o && !we_i |-> dat_o[31:8] == 24'h0)
        else $error("read upper bits set");
    low_pins_a: assert property (port1_out_o[2:0] == 3'h0 && port1_oe_n_o[2:0] == 3'h7)
        else $error("unused port bits driven");
    irq_drop_a: assert property ($fell(irq_o) |-> wr_q || wr2_q)
        else $error("interrupt dropped without software");
    oe_mode_a: assert property ($changed(port1_oe_n_o) |-> wr_q || wr2_q)
        else $error("pin drive changed without mode write");
    wdt_once_a: assert property (wdt_reset_o |=> !wdt_reset_o)
        else $error("watchdog pulse too long");
endmodule : pca_checker
bind pca_top pca_checker checker_inst (.clk_i(clk_i), .rst_i(rst_i), .cyc_i(cyc_i),
    .stb_i(stb_i), .we_i(we_i), .dat_o(dat_o), .ack_o(ack_o), .port1_out_o(port1_out_o),
    .port1_oe_n_o(port1_oe_n_o), .irq_o(irq_o), .wdt_reset_o(wdt_reset_o));
`default_nettype wire

// *** tb/counter_array_capture_compare_tb.sv ***
// self-checking bench for the counter array
`timescale 1ns/1ps
`default_nettype none
module counter_array_capture_compare_tb;
    import pca_pkg::*;
    logic        clk_i = 1'b0, rst_i = 1'b1, cyc_i = 1'b0, stb_i = 1'b0, we_i = 1'b0;
    logic        idle_i = 1'b0, t0_i = 1'b0, ack_o, irq_o, wdt_o;
    logic [7:0]  adr_i = 8'h00, pins, p_out, p_oe, m;
    logic [31:0] dat_i = 32'h0, dat_o, q, seed = 32'h82162849;
    logic [15:0] v, old, r;
    int          fail_count = 0, num_checks = 0, wdt_seen = 0, k, n;
    always #2 clk_i = ~clk_i;
    always @(posedge clk_i) if (wdt_o === 1'b1) wdt_seen++;
    pca_top dut (.clk_i(clk_i), .rst_i(rst_i), .cyc_i(cyc_i), .stb_i(stb_i), .we_i(we_i),
        .adr_i(adr_i), .sel_i(4'hF), .dat_i(dat_i), .dat_o(dat_o), .ack_o(ack_o),
        .cpu_idle_i(idle_i), .timer0_overflow_i(t0_i), .port1_in_i(pins),
        .port1_out_o(p_out), .port1_oe_n_o(p_oe), .irq_o(irq_o), .wdt_reset_o(wdt_o));
    pin_agent agent (.clk_i(clk_i), .pins_o(pins));
    function automatic logic [31:0] rnd();
        seed ^= seed << 13;
        seed ^= seed >> 17;
        seed ^= seed << 5;
        return seed;
    endfunction : rnd
    function automatic logic [7:0] at(input logic [7:0] b);
        return b + (m << 2);
    endfunction : at
    task automatic print_verdict();
        $display("checks %0d errors %0d", num_checks, fail_count);
        if (fail_count == 0 && num_checks > 0)
            $display("Finished cleanly");
        else
            $display("Finished with errors");
        $finish;
    endtask : print_verdict
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        num_checks++;
        if (got !== exp)
        begin
            fail_count++;
            $display("wrong value at %0t: got %h expected %h", $time, got, exp);
        end
    endtask : chk
    task automatic bus(input logic w, input logic [7:0] a, input logic [7:0] d);
        int i;
        i = 0;
        cyc_i <= 1'b1;
        stb_i <= 1'b1;
        we_i  <= w;
        adr_i <= a;
        dat_i <= {24'h0, d};
        // look at ack between edges, then take the answer at the edge that samples it
        do
        begin
            @(negedge clk_i);
            i++;
        end
        while (ack_o !== 1'b1 && i < 20);
        if (i >= 20)
        begin
            fail_count++;
            print_verdict();
        end
        @(posedge clk_i);
        q = dat_o;
        cyc_i <= 1'b0;
        stb_i <= 1'b0;
        @(posedge clk_i);
    endtask : bus
    task automatic tick(input int c);
        repeat (c)
        begin
            t0_i <= 1'b1;
            @(posedge clk_i);
            t0_i <= 1'b0;
            @(posedge clk_i);
        end
        repeat (3) @(posedge clk_i);
    endtask : tick
    task automatic do_reset();
        rst_i <= 1'b1;
        repeat (16) @(posedge clk_i);
        rst_i <= 1'b0;
        wdt_seen = 0;
        @(posedge clk_i);
    endtask : do_reset
    task automatic rd_cmp(output logic [15:0] x);
        bus(1'b0, at(OFS_LO_BASE), 8'h00);
        x[7:0] = q[7:0];
        bus(1'b0, at(OFS_HI_BASE), 8'h00);
        x[15:8] = q[7:0];
    endtask : rd_cmp
    initial
    begin
        do_reset();
        for (int a = 0; a < 8'h50; a += 4)
        begin
            bus(1'b0, a[7:0], 8'h00);
            chk(q, 32'h0);
        end
        bus(1'b1, 8'h80, 8'h5A);
        bus(1'b0, 8'h80, 8'h00);
        chk(q, 32'h0);
        bus(1'b1, OFS_MODE_BASE, 8'hFF);
        bus(1'b0, OFS_MODE_BASE, 8'h00);
        chk(q, 32'h7F);
        for (int c = 0; c < 2; c++)
        begin
            do_reset();
            k = int'(rnd() % 40) + 1;
            bus(1'b1, OFS_COUNTER_MODE_REGISTER, c ? 8'h84 : 8'h04);
            bus(1'b1, OFS_COUNTER_CONTROL, 8'h40);
            tick(k);
            idle_i <= 1'b1;
            tick(5);
            idle_i <= 1'b0;
            bus(1'b1, OFS_COUNTER_CONTROL, 8'h00);
            tick(4);
            bus(1'b0, OFS_CL, 8'h00);
            chk(q, k + (c ? 0 : 5));
        end
        // phase of the divider is unknown, so one tick of slack below and two above
        for (int s = 0; s < 4; s++)
        begin
            do_reset();
            n = s[1] ? (s[0] ? 2 : 4) : (s[0] ? 6 : 12);
            bus(1'b1, OFS_AUX, {7'h0, s[0]});
            bus(1'b1, OFS_COUNTER_MODE_REGISTER, s[1] ? 8'h02 : 8'h00);
            bus(1'b1, OFS_COUNTER_CONTROL, 8'h40);
            repeat (96) @(posedge clk_i);
            bus(1'b1, OFS_COUNTER_CONTROL, 8'h00);
            bus(1'b0, OFS_CL, 8'h00);
            k = 96 / n;
            chk(q >= k - 1 && q <= k + 2, 1);
        end
        do_reset();
        bus(1'b1, OFS_COUNTER_MODE_REGISTER, 8'h06);
        bus(1'b1, OFS_COUNTER_CONTROL, 8'h40);
        k = int'(rnd() % 6) + 1;
        agent.eci_pulse(k);
        bus(1'b0, OFS_CL, 8'h00);
        chk(q, k);
        do_reset();
        bus(1'b1, OFS_COUNTER_MODE_REGISTER, 8'h05);
        bus(1'b1, OFS_CL, 8'hFE);
        bus(1'b1, OFS_CH, 8'hFF);
        bus(1'b1, OFS_COUNTER_CONTROL, 8'h40);
        tick(5);
        bus(1'b0, OFS_COUNTER_CONTROL, 8'h00);
        chk({irq_o, q[7:0]}, 9'h1C0);
        bus(1'b0, OFS_CL, 8'h00);
        chk(q, 32'h3);
        bus(1'b1, OFS_COUNTER_CONTROL, 8'h40);
        bus(1'b0, OFS_COUNTER_CONTROL, 8'h00);
        chk({irq_o, q[7:0]}, 9'h040);
        do_reset();
        m = 8'(rnd() % 5);
        v = 16'(rnd()) & 16'h7FFF;
        bus(1'b1, OFS_COUNTER_MODE_REGISTER, 8'h04);
        bus(1'b1, OFS_CL, v[7:0]);
        bus(1'b1, OFS_CH, v[15:8]);
        bus(1'b1, at(OFS_MODE_BASE), 8'h4D);
        v = v + 16'h2;
        bus(1'b1, at(OFS_LO_BASE), v[7:0]);
        bus(1'b1, at(OFS_HI_BASE), v[15:8]);
        chk(p_oe[m + 3], 1'b0);
        bus(1'b1, OFS_COUNTER_CONTROL, 8'h40);
        tick(2);
        chk({irq_o, p_out}, {1'b1, 8'h08 << m});
        bus(1'b0, OFS_COUNTER_CONTROL, 8'h00);
        chk(q, 32'h40 | (32'h1 << m));
        for (int w = 0; w < 2; w++)
        begin
            do_reset();
            m = 8'h4;
            bus(1'b1, OFS_COUNTER_MODE_REGISTER, w ? 8'h44 : 8'h04);
            bus(1'b1, at(OFS_MODE_BASE), 8'h48);
            bus(1'b1, at(OFS_LO_BASE), 8'h02);
            bus(1'b1, OFS_COUNTER_CONTROL, 8'h40);
            tick(4);
            chk(wdt_seen, w);
        end
        do_reset();
        m = 8'(rnd() % 5);
        old = 16'h0;
        bus(1'b1, OFS_COUNTER_MODE_REGISTER, 8'h04);
        for (int e = 0; e < 2; e++)
        begin
            v = 16'(rnd());
            bus(1'b1, OFS_CL, v[7:0]);
            bus(1'b1, OFS_CH, v[15:8]);
            bus(1'b1, at(OFS_MODE_BASE), e ? 8'h10 : 8'h20);
            agent.set_pin(m + 3, e[0]);
            rd_cmp(r);
            chk(r, old);
            agent.set_pin(m + 3, !e[0]);
            rd_cmp(r);
            chk(r, v);
            old = v;
        end
        bus(1'b0, OFS_COUNTER_CONTROL, 8'h00);
        chk(q, 32'h1 << m);
        do_reset();
        bus(1'b1, OFS_COUNTER_MODE_REGISTER, 8'h04);
        bus(1'b1, at(OFS_MODE_BASE), 8'h42);
        bus(1'b1, at(OFS_HI_BASE), 8'h80);
        bus(1'b1, OFS_CL, 8'hFF);
        chk(p_out[m + 3], 1'b1);
        bus(1'b1, OFS_COUNTER_CONTROL, 8'h40);
        tick(1);
        chk(p_out[m + 3], 1'b0);
        bus(1'b1, OFS_CL, 8'h90);
        repeat (3) @(posedge clk_i);
        chk(p_out[m + 3], 1'b1);
        print_verdict();
    end
endmodule : counter_array_capture_compare_tb
`default_nettype wire
